// ==== vst_supervisor.sv ====
// valve stroke test supervisor: switches, solenoid gating, closure recorder, lamps
`timescale 1ns/1ps

module vst_supervisor
  import vst_pkg::*;
#(
  parameter int DEBOUNCE_CYCLES = DEBOUNCE_CYC           // shorten for simulation
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [1:0]  supply_ok,                    // shutdown supply present, per input
  input  wire logic [1:0]  test_sw,                      // test contact closed
  input  wire logic [1:0]  reset_sw,                     // reset contact closed
  output logic      [1:0]  sol_drive,                    // solenoid output powered
  output logic      [1:0]  supply_return_en,             // supply return path closed
  output logic             lamp_pass_sink,
  output logic             lamp_fail_sink,
  output logic             dcs_pass_open,
  output logic             dcs_fail_open
);

  // ==========================================================================
  // contact debouncing
  // ==========================================================================
  vst_sw_if #(.N(4)) sw_if ();                           // {reset2, reset1, test2, test1}

  assign sw_if.raw = {reset_sw, test_sw};

  vst_debounce #(
    .N          (4),
    .CNT_W      (DEB_CNT_W),
    .STABLE_CYC (DEB_CNT_W'(DEBOUNCE_CYCLES))
  ) u_deb (
    .pclk    (pclk),
    .presetn (presetn),
    .sw      (sw_if)
  );

  // ==========================================================================
  // state
  // ==========================================================================
  typedef struct packed {
    logic [CTRL_W-1:0]  ctrl;                            // configuration register
    logic [CAP_W-1:0]   cap_len;                         // capture duration, cycles
    vst_state_t         st;                              // test / result state
    logic               fc_test;                         // running test is a full closure
    logic [1:0]         reset_ok;                        // solenoid supply restored
    logic [1:0]         sol;                             // solenoid outputs
    logic [1:0]         ret;                             // return path enables
    logic               test_prev;                       // combined test contact, last cycle
    logic               rst_prev;                        // combined reset contact, last cycle
    logic [1:0]         sup_prev;                        // supplies, last cycle
    logic               trip_prev;                       // recorder trip level, last cycle
    logic               capturing;                       // closure capture running
    logic [CAP_W-1:0]   cap_cnt;                         // cycles left in capture
    logic [EV_W-1:0]    cap_word;                        // event being captured
    logic [1:0]         ev_cnt;                          // pending events
    logic [EV_W-1:0]    ev0;                             // oldest event
    logic [EV_W-1:0]    ev1;                             // queued event
    logic               lamp_p;
    logic               lamp_f;
    logic [31:0]        rdata;                           // read data, loaded at setup
  } vst_top_t;

  vst_top_t q_r;                                         // registered state
  vst_top_t q_nxt;                                       // next state

  // ==========================================================================
  // apb decode
  // ==========================================================================
  logic        setup_ph;                                 // first cycle of a transfer
  logic        access_ph;                                // completing cycle
  logic        mapped;                                   // address hits a register
  logic        wr_en;                                    // write takes effect now
  logic [31:0] cmd;                                      // command strobes this cycle

  assign setup_ph  = psel & ~penable;
  assign access_ph = psel & penable;
  assign mapped    = (paddr == REG_CTRL) || (paddr == REG_CAPLEN) || (paddr == REG_CMD) ||
                     (paddr == REG_STATUS) || (paddr == REG_EVENT);
  assign wr_en     = access_ph & pwrite;
  assign cmd       = (wr_en && paddr == REG_CMD) ? pwdata : 32'h0000_0000;

  // no wait state: read data is fetched in setup and held in a flop
  assign pready  = access_ph;
  assign pslverr = access_ph & ~mapped;
  assign prdata  = q_r.rdata;

  // ==========================================================================
  // next state
  // ==========================================================================
  always_comb begin
    logic         test_lvl;                              // either test contact closed
    logic         rst_lvl;                               // either reset contact closed
    logic         test_open;                             // test contact just released
    logic         rst_close;                             // reset contact just made
    logic         start_pst;                             // partial stroke request
    logic         start_fc;                              // full closure request
    logic         tv;                                    // index of the valve under test
    logic         pst_ok;                                // partial stroke allowed
    logic         trip;                                  // recorder trip condition
    logic         drop;                                  // any supply fell
    logic         rec_arm;                               // recorder may run
    logic         commit;                                // capture finished this cycle
    logic         testing;
    logic [1:0]   man;                                   // manual reset per solenoid
    test_lvl  = 1'b0;
    rst_lvl   = 1'b0;
    test_open = 1'b0;
    rst_close = 1'b0;
    start_pst = 1'b0;
    start_fc  = 1'b0;
    tv        = 1'b0;
    pst_ok    = 1'b0;
    trip      = 1'b0;
    drop      = 1'b0;
    rec_arm   = 1'b0;
    commit    = 1'b0;
    testing   = 1'b0;
    man       = 2'b00;
    q_nxt     = q_r;

    // register writes
    if (wr_en && paddr == REG_CTRL) begin
      q_nxt.ctrl = pwdata[CTRL_W-1:0];
    end
    if (wr_en && paddr == REG_CAPLEN) begin
      q_nxt.cap_len = pwdata[CAP_W-1:0];
    end

    // contact edges on debounced levels
    test_lvl        = sw_if.clean[0] | sw_if.clean[1];
    rst_lvl         = sw_if.clean[2] | sw_if.clean[3];
    test_open       = q_r.test_prev & ~test_lvl;
    rst_close       = rst_lvl & ~q_r.rst_prev;
    q_nxt.test_prev = test_lvl;
    q_nxt.rst_prev  = rst_lvl;

    // solenoid supply reset, manual or automatic
    man = {q_r.ctrl[CTRL_MAN_RESET2], q_r.ctrl[CTRL_MAN_RESET1]};
    for (int i = 0; i < 2; i++) begin
      if (!supply_ok[i]) begin
        q_nxt.reset_ok[i] = 1'b0;                        // supply lost: needs reset again
      end else if (!q_r.reset_ok[i]) begin
        q_nxt.reset_ok[i] = man[i] ? rst_close : 1'b1;
      end
    end

    // test start and result
    tv        = q_r.ctrl[CTRL_TEST_VALVE];
    drop      = |(q_r.sup_prev & ~supply_ok);
    start_pst = test_open | cmd[CMD_START_PST];
    start_fc  = cmd[CMD_START_FC];
    pst_ok    = q_r.ctrl[CTRL_CONFIGURED] & q_r.reset_ok[tv] &
                (q_r.ev_cnt == 2'h0) & ~q_r.capturing;
    q_nxt.sup_prev = supply_ok;

    if (drop) begin
      q_nxt.st      = VST_IDLE;                          // shutdown: result cleared
      q_nxt.fc_test = 1'b0;
    end else if (q_r.st == VST_TEST) begin
      if (cmd[CMD_ABORT]) begin
        q_nxt.st = VST_IDLE;
      end else if (cmd[CMD_RES_WARN]) begin
        q_nxt.st = VST_WARN;
      end else if (cmd[CMD_RES_FAIL]) begin
        q_nxt.st = VST_FAIL;
      end else if (cmd[CMD_RES_PASS]) begin
        q_nxt.st = VST_PASS;
      end
    end else if (start_fc && q_r.ctrl[CTRL_CONFIGURED] && q_r.reset_ok[tv]) begin
      q_nxt.st      = VST_TEST;
      q_nxt.fc_test = 1'b1;
    end else if (start_pst && pst_ok) begin
      q_nxt.st      = VST_TEST;
      q_nxt.fc_test = 1'b0;
    end

    // closure recorder
    rec_arm = q_r.ctrl[CTRL_REC_ENABLE] & q_r.ctrl[CTRL_NORM_ENERG];
    trip    = q_r.ctrl[CTRL_DUAL_TRIP] ? ~(supply_ok[0] | supply_ok[1])
                                       : ~supply_ok[0];
    q_nxt.trip_prev = trip;
    commit  = q_r.capturing & (q_r.cap_cnt <= CAP_W'(1));
    if (commit) begin
      q_nxt.capturing = 1'b0;
      q_nxt.cap_cnt   = '0;
    end else if (q_r.capturing) begin
      q_nxt.cap_cnt = q_r.cap_cnt - CAP_W'(1);
    end else if (rec_arm && trip && !q_r.trip_prev && q_r.ev_cnt < EV_DEPTH) begin
      q_nxt.capturing = 1'b1;
      q_nxt.cap_cnt   = q_r.cap_len;
      q_nxt.cap_word  = {1'b0, ~supply_ok};
    end

    // event store: download first, then a finished capture takes the free slot
    if (cmd[CMD_DOWNLOAD] && q_r.ev_cnt != 2'h0) begin
      q_nxt.ev0    = q_r.ev1;
      q_nxt.ev1    = '0;
      q_nxt.ev_cnt = q_r.ev_cnt - 2'h1;
    end
    if (commit) begin
      if (q_nxt.ev_cnt == 2'h0) begin
        q_nxt.ev0 = q_r.cap_word;
      end else begin
        q_nxt.ev1 = q_r.cap_word;
      end
      q_nxt.ev_cnt = q_nxt.ev_cnt + 2'h1;
    end

    // full closure result replaces whatever closure is stored
    if (q_r.st == VST_TEST && q_r.fc_test && !drop &&
        (cmd[CMD_RES_PASS] | cmd[CMD_RES_FAIL] | cmd[CMD_RES_WARN]) &&
        q_nxt.ev_cnt != 2'h0) begin
      q_nxt.ev0    = EV_FC_WORD;
      q_nxt.ev1    = '0;
      q_nxt.ev_cnt = 2'h1;
    end

    // solenoid gating from the supplies
    testing = (q_nxt.st == VST_TEST);
    for (int i = 0; i < 2; i++) begin
      q_nxt.ret[i] = ~(testing & (tv == i[0]));
      q_nxt.sol[i] = supply_ok[i] & q_nxt.reset_ok[i] & q_nxt.ret[i];
    end

    // lamps and status contacts
    q_nxt.lamp_p = q_nxt.ctrl[CTRL_CONFIGURED] &
                   (q_nxt.st == VST_PASS || q_nxt.st == VST_WARN);
    q_nxt.lamp_f = q_nxt.ctrl[CTRL_CONFIGURED] &
                   (q_nxt.st == VST_FAIL || q_nxt.st == VST_WARN);

    // read data fetched in the setup cycle
    if (setup_ph && !pwrite) begin
      unique case (paddr)
        REG_CTRL:   q_nxt.rdata = {{(32-CTRL_W){1'b0}}, q_r.ctrl};
        REG_CAPLEN: q_nxt.rdata = {{(32-CAP_W){1'b0}}, q_r.cap_len};
        REG_STATUS: q_nxt.rdata = {18'h0_0000, q_r.sol, test_lvl, rst_lvl, supply_ok,
                                   q_r.reset_ok, q_r.capturing, q_r.ev_cnt, q_r.st};
        REG_EVENT:  q_nxt.rdata = {{(32-EV_W){1'b0}}, q_r.ev0};
        default:    q_nxt.rdata = 32'h0000_0000;         // command and unmapped
      endcase
    end
  end

  // register the state copy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_r          <= '0;
      q_r.ctrl     <= CTRL_RST;
      q_r.cap_len  <= CAPLEN_RST;
      q_r.st       <= VST_IDLE;
      q_r.ret      <= 2'b11;
    end else begin
      q_r <= q_nxt;
    end
  end

  // ==========================================================================
  // outputs
  // ==========================================================================
  assign sol_drive        = q_r.sol;
  assign supply_return_en = q_r.ret;
  assign lamp_pass_sink   = q_r.lamp_p;
  assign lamp_fail_sink   = q_r.lamp_f;
  assign dcs_pass_open    = q_r.lamp_p;
  assign dcs_fail_open    = q_r.lamp_f;

endmodule : vst_supervisor

// ==== vst_pkg.sv ====
// constants, register map and types for the valve stroke test supervisor
package vst_pkg;

  // ==========================================================================
  // timing
  // ==========================================================================
  localparam int CLK_HZ         = 100_000_000;           // pclk rate
  localparam int DEBOUNCE_MS    = 10;                    // least stable contact time
  localparam int DEBOUNCE_CYC   = (DEBOUNCE_MS * (CLK_HZ / 1000)); // exact: CLK_HZ is a multiple of 1000
  localparam int DEB_CNT_W      = 20;                    // holds DEBOUNCE_CYC
  localparam int CAP_W          = 24;                    // capture length counter width

  // ==========================================================================
  // register byte offsets
  // ==========================================================================
  localparam logic [7:0] REG_CTRL    = 8'h00;            // configuration bits
  localparam logic [7:0] REG_CAPLEN  = 8'h04;            // closure capture length, cycles
  localparam logic [7:0] REG_CMD     = 8'h08;            // command strobes, read zero
  localparam logic [7:0] REG_STATUS  = 8'h0C;            // live state
  localparam logic [7:0] REG_EVENT   = 8'h10;            // oldest pending closure event

  // ==========================================================================
  // control field positions and reset values
  // ==========================================================================
  localparam int CTRL_W            = 7;
  localparam int CTRL_CONFIGURED   = 0;                  // unit commissioned
  localparam int CTRL_NORM_ENERG   = 1;                  // solenoids normally energised
  localparam int CTRL_REC_ENABLE   = 2;                  // recorder_enable_select
  localparam int CTRL_DUAL_TRIP    = 3;                  // dual_supply_trip_select
  localparam int CTRL_MAN_RESET1   = 4;                  // manual reset, solenoid 1
  localparam int CTRL_MAN_RESET2   = 5;                  // manual reset, solenoid 2
  localparam int CTRL_TEST_VALVE   = 6;                  // 0: solenoid 1, 1: solenoid 2
  localparam logic [CTRL_W-1:0] CTRL_RST   = 7'h00;
  localparam logic [CAP_W-1:0]  CAPLEN_RST = 24'h000100;

  // ==========================================================================
  // command strobe positions
  // ==========================================================================
  localparam int CMD_START_PST  = 0;                     // server-started partial stroke
  localparam int CMD_START_FC   = 1;                     // full closure test
  localparam int CMD_RES_PASS   = 2;
  localparam int CMD_RES_FAIL   = 3;
  localparam int CMD_RES_WARN   = 4;                     // pass with warning
  localparam int CMD_DOWNLOAD   = 5;                     // pop oldest closure event
  localparam int CMD_ABORT      = 6;

  // ==========================================================================
  // event word: [0] supply 1 dropped, [1] supply 2 dropped, [2] full closure test
  // ==========================================================================
  localparam int EV_W    = 3;
  localparam int EV_FC   = 2;
  localparam logic [EV_W-1:0] EV_FC_WORD = 3'h4;
  localparam logic [1:0]      EV_DEPTH   = 2'h2;         // two pending events at most

  // ==========================================================================
  // test state, gray along idle-test-pass-fail-warn
  // ==========================================================================
  typedef enum logic [2:0] {
    VST_IDLE = 3'h0,                                     // no result: lamps dark
    VST_TEST = 3'h1,
    VST_PASS = 3'h3,
    VST_FAIL = 3'h2,
    VST_WARN = 3'h6
  } vst_state_t;

endpackage : vst_pkg

// ==== vst_sw_if.sv ====
// carrier between the supervisor and its contact debouncer
`timescale 1ns/1ps
interface vst_sw_if #(parameter int N = 4);
  logic [N-1:0] raw;                                     // contact closed = 1
  logic [N-1:0] clean;                                   // debounced level
  modport deb  (input raw, output clean);
  modport user (output raw, input clean);
endinterface : vst_sw_if

// ==== vst_debounce.sv ====
// two-flop synchroniser and stability filter per contact
`timescale 1ns/1ps
module vst_debounce
  import vst_pkg::*;
#(
  parameter int                 N          = 4,
  parameter int                 CNT_W      = DEB_CNT_W,
  parameter logic [CNT_W-1:0]   STABLE_CYC = CNT_W'(DEBOUNCE_CYC)
) (
  input  wire logic  pclk,
  input  wire logic  presetn,
  vst_sw_if.deb      sw
);

  // ==========================================================================
  // state
  // ==========================================================================
  typedef struct packed {
    logic [N-1:0]            s1;                         // first sync stage
    logic [N-1:0]            s2;                         // second sync stage
    logic [N-1:0]            lvl;                        // accepted level
    logic [N-1:0][CNT_W-1:0] cnt;                        // cycles the input differed
  } vst_deb_t;

  vst_deb_t q_r;                                         // registered state
  vst_deb_t q_nxt;                                       // next state

  // ==========================================================================
  // filter: a level is accepted only after it has held steadily
  // ==========================================================================
  always_comb begin
    q_nxt    = q_r;
    q_nxt.s1 = sw.raw;
    q_nxt.s2 = q_r.s1;                                   // only reader of s1
    for (int i = 0; i < N; i++) begin
      if (q_r.s2[i] == q_r.lvl[i]) begin
        q_nxt.cnt[i] = '0;                               // bounce back resets the wait
      end else if (q_r.cnt[i] == STABLE_CYC - CNT_W'(1)) begin
        q_nxt.lvl[i] = q_r.s2[i];
        q_nxt.cnt[i] = '0;
      end else begin
        q_nxt.cnt[i] = q_r.cnt[i] + CNT_W'(1);
      end
    end
  end

  // register the state copy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign sw.clean = q_r.lvl;

endmodule : vst_debounce

// ==== vst_supervisor_checker.sv ====
// pin-level checks for the valve stroke test supervisor
`timescale 1ns/1ps
module vst_supervisor_checker (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [1:0]  supply_ok,
  input wire logic [1:0]  test_sw,
  input wire logic [1:0]  reset_sw,
  input wire logic [1:0]  sol_drive,
  input wire logic [1:0]  supply_return_en,
  input wire logic        lamp_pass_sink,
  input wire logic        lamp_fail_sink,
  input wire logic        dcs_pass_open,
  input wire logic        dcs_fail_open
);
  // one clock domain, so clock and reset are given once
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ====================
  // lamps and status contacts
  // ====================
  lamp_contact_a: assert property (
    {dcs_pass_open, dcs_fail_open} == {lamp_pass_sink, lamp_fail_sink})
    else $error("status contacts differ from lamps");
  dark_test_a: assert property (
    supply_return_en != 2'h3 ##1 supply_return_en != 2'h3 |-> !lamp_pass_sink && !lamp_fail_sink)
    else $error("lamp lit while a test runs");
  dark_drop_a: assert property (
    $fell(supply_ok[0]) || $fell(supply_ok[1]) |-> ##[1:3] !lamp_pass_sink && !lamp_fail_sink)
    else $error("lamp still lit after a supply drop");
  // ====================
  // solenoid gating, test start and apb handshake
  // ====================
  sol1_source_a: assert property (
    !supply_ok[0] [*3] |-> !sol_drive[0])
    else $error("solenoid 1 fed without supply 1");
  sol2_source_a: assert property (
    !supply_ok[1] [*3] |-> !sol_drive[1])
    else $error("solenoid 2 fed without supply 2");
  return_gate_a: assert property (
    ((~supply_return_en) & sol_drive) == 2'h0)
    else $error("solenoid fed with its return open");
  one_return_a: assert property (
    supply_return_en != 2'h0)
    else $error("both return paths open");
  // bench never starts a test by command while a contact is held
  start_open_a: assert property (
    supply_return_en != 2'h3 && $past(supply_return_en) == 2'h3 |-> test_sw == 2'h0)
    else $error("test started with a contact closed");
  apb_ready_a: assert property (psel && penable |-> pready)
    else $error("no ready in access cycle");
  apb_err_a: assert property (psel && penable && paddr > 8'h10 |-> pslverr)
    else $error("unmapped access not refused");
endmodule : vst_supervisor_checker

bind vst_supervisor vst_supervisor_checker chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .supply_ok(supply_ok), .test_sw(test_sw),
  .reset_sw(reset_sw), .sol_drive(sol_drive), .supply_return_en(supply_return_en),
  .lamp_pass_sink(lamp_pass_sink), .lamp_fail_sink(lamp_fail_sink),
  .dcs_pass_open(dcs_pass_open), .dcs_fail_open(dcs_fail_open));

// ==== vst_plant.sv ====
// plant side model: shutdown supplies and operator contacts
`timescale 1ns/1ps
module vst_plant (
  input  wire logic       pclk,
  output logic      [1:0] supply_ok,                     // supply present
  output logic      [1:0] test_sw,                       // test contact closed
  output logic      [1:0] reset_sw                       // reset contact closed
);
  // everything off at power-up
  initial begin
    supply_ok = 2'h0;
    test_sw = 2'h0;
    reset_sw = 2'h0;
  end
  // supply level changes just after an edge
  task automatic supply(input logic [1:0] v);
    @(posedge pclk);
    supply_ok <= v;
  endtask : supply
  // close a contact, then open it; hold sets prompt or slow operator
  task automatic press(input logic rst, input int idx, input int hold);
    @(posedge pclk);
    if (rst) reset_sw[idx] <= 1'b1;
    else test_sw[idx] <= 1'b1;
    repeat (hold) @(posedge pclk);
    reset_sw <= 2'h0;
    test_sw <= 2'h0;
    repeat (hold) @(posedge pclk);
  endtask : press
endmodule : vst_plant

// ==== vst_supervisor_bench.sv ====
// self-checking bench for the valve stroke test supervisor
`timescale 1ns/1ps
module vst_supervisor_bench
  import vst_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0]  supply_ok, test_sw, reset_sw, sol_drive, ret_en;
  logic        lamp_pass, lamp_fail, dcs_pass, dcs_fail;
  int          mismatches, total_checks, i;
  localparam logic [1:0] LAMP[3] = '{2'h2, 2'h1, 2'h3};   // pass, fail, warn
  localparam vst_state_t ST[3] = '{VST_PASS, VST_FAIL, VST_WARN};
  initial pclk = 1'b0;
  always #5 pclk = ~pclk;
  // short filter keeps contact presses to a few cycles
  vst_supervisor #(.DEBOUNCE_CYCLES(4)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .supply_ok(supply_ok), .test_sw(test_sw),
    .reset_sw(reset_sw), .sol_drive(sol_drive), .supply_return_en(ret_en),
    .lamp_pass_sink(lamp_pass), .lamp_fail_sink(lamp_fail), .dcs_pass_open(dcs_pass),
    .dcs_fail_open(dcs_fail));
  vst_plant plant (.pclk(pclk), .supply_ok(supply_ok), .test_sw(test_sw), .reset_sw(reset_sw));
  // ====================
  // tasks
  // ====================
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // one transfer; request held until pready is seen
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no wait-state count assumed: only the watchdog ends a hung wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(rd & m, e);
  endtask : rdchk
  // supply drop with capture flag looked at mid-capture
  task automatic drop(input logic [1:0] v, input logic cap);
    plant.supply(v);
    repeat (2) @(posedge pclk);
    rdchk(REG_STATUS, 32'h20, {cap, 5'h0});
    repeat (16) @(posedge pclk);
    plant.supply(2'h3);
    repeat (4) @(posedge pclk);
  endtask : drop
  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_sim
  // ====================
  // sequence
  // ====================
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    mismatches = 0;
    total_checks = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(REG_CTRL, 32'hFFFFFFFF, 32'h0);
    rdchk(REG_CAPLEN, 32'hFFFFFFFF, 32'h100);
    rdchk(REG_STATUS, 32'hFFFFFFFF, 32'h0);
    check({lamp_pass, lamp_fail}, 2'h0);
    apb(1'b0, 8'h14, 32'h0);
    check(err, 1'b1);
    apb(1'b1, REG_CTRL, 32'h3);
    plant.press(1'b0, 0, 12);
    rdchk(REG_STATUS, 32'h7, VST_IDLE);
    plant.supply(2'h3);
    repeat (6) @(posedge pclk);
    check(sol_drive, 2'h3);
    for (i = 0; i < 3; i++) begin
      plant.press(1'b0, i % 2, 12 + 4 * i);
      check(ret_en, 2'h2);
      apb(1'b1, REG_CMD, 32'h1 << (CMD_RES_PASS + i));
      rdchk(REG_STATUS, 32'h7, ST[i]);
      check({lamp_pass, lamp_fail}, LAMP[i]);
    end
    apb(1'b1, REG_CTRL, 32'h0);
    rdchk(REG_STATUS, 32'h7, VST_WARN);
    check({lamp_pass, lamp_fail}, 2'h0);
    apb(1'b1, REG_CTRL, 32'h3);
    plant.supply(2'h2);
    repeat (4) @(posedge pclk);
    check({lamp_pass, lamp_fail}, 2'h0);
    check(sol_drive, 2'h2);
    apb(1'b1, REG_CTRL, 32'h53);
    plant.supply(2'h3);
    repeat (6) @(posedge pclk);
    plant.press(1'b0, 1, 12);
    check(ret_en, 2'h1);
    apb(1'b1, REG_CMD, 32'h1 << CMD_ABORT);
    // back to solenoid 1, whose supply still waits for its manual reset
    apb(1'b1, REG_CTRL, 32'h13);
    check(sol_drive, 2'h2);
    plant.press(1'b0, 0, 12);
    rdchk(REG_STATUS, 32'h7, VST_IDLE);
    plant.press(1'b1, 1, 12);
    check(sol_drive, 2'h3);
    apb(1'b1, REG_CAPLEN, 32'h8);
    apb(1'b1, REG_CTRL, 32'h5);
    drop(2'h2, 1'b0);
    apb(1'b1, REG_CTRL, 32'h3);
    drop(2'h2, 1'b0);
    apb(1'b1, REG_CTRL, 32'h7);
    for (i = 0; i < 3; i++) drop(2'h2, i < 2);
    rdchk(REG_STATUS, 32'h18, 32'h10);
    rdchk(REG_EVENT, 32'h7, 32'h1);
    plant.press(1'b0, 0, 12);
    rdchk(REG_STATUS, 32'h7, VST_IDLE);
    apb(1'b1, REG_CMD, 32'h1 << CMD_DOWNLOAD);
    rdchk(REG_STATUS, 32'h18, 32'h08);
    apb(1'b1, REG_CMD, 32'h1 << CMD_START_FC);
    apb(1'b1, REG_CMD, 32'h1 << CMD_RES_PASS);
    rdchk(REG_EVENT, 32'h7, EV_FC_WORD);
    apb(1'b1, REG_CMD, 32'h1 << CMD_DOWNLOAD);
    apb(1'b1, REG_CTRL, 32'hF);
    drop(2'h2, 1'b0);
    drop(2'h0, 1'b1);
    end_sim();
  end
  // hang guard: whole sequence needs about 540 cycles
  initial begin
    #100us;
    mismatches++;
    end_sim();
  end
endmodule : vst_supervisor_bench
